// ==== logic/rcs_alarm_match.sv ====
// Compares enabled alarm set-points with the current count fields
`timescale 1ns/1ps
`include "rcs_map.svh"
module rcs_alarm_match (
  input  wire logic               [`RCS_AEN_W-1:0] enables,
  input  wire rcs_pkg::rcs_byte_t set_sec,
  input  wire rcs_pkg::rcs_byte_t set_min,
  input  wire rcs_pkg::rcs_byte_t set_hrs,
  input  wire rcs_pkg::rcs_byte_t set_dow,
  input  wire rcs_pkg::rcs_byte_t count_sec,
  input  wire rcs_pkg::rcs_byte_t count_min,
  input  wire rcs_pkg::rcs_byte_t count_hour,
  input  wire rcs_pkg::rcs_byte_t count_dow,
  output logic                    match
);

  // A disabled field never blocks the match
  function automatic logic field_ok(input logic en,
                                    input rcs_pkg::rcs_byte_t a,
                                    input rcs_pkg::rcs_byte_t b);
    return !en || (a == b);
  endfunction

  // Raw equality: both sides are held in the same coding
  always_comb begin
    match = (enables != `RCS_AEN_ZERO)
      && field_ok(enables[`RCS_AEN_SEC], set_sec, count_sec)
      && field_ok(enables[`RCS_AEN_MIN], set_min, count_min)
      && field_ok(enables[`RCS_AEN_HRS], set_hrs, count_hour)
      && field_ok(enables[`RCS_AEN_DOW], set_dow, count_dow);
  end

endmodule

// ==== logic/rcs_century_counter.sv ====
// Hundred-year count register with locked-write gating and carry increment
`timescale 1ns/1ps
`include "rcs_map.svh"
module rcs_century_counter (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             bcd_mode,
  input  wire logic             count_unlock,
  input  wire logic             wr_en,
  input  wire rcs_pkg::rcs_byte_t wdata,
  input  wire logic             year_carry,
  output rcs_pkg::rcs_byte_t    century
);

  rcs_pkg::rcs_byte_t cen_q;
  rcs_pkg::rcs_byte_t cen_d;

  // Packed decimal or binary step, wrapping to zero
  function automatic rcs_pkg::rcs_byte_t step(input rcs_pkg::rcs_byte_t v,
                                              input logic bcd);
    rcs_pkg::rcs_byte_t r;
    r = v + `RCS_BYTE_ONE;
    if (bcd) begin
      if (v[3:0] >= `RCS_NIB_NINE) begin
        r[3:0] = `RCS_NIB_ZERO;
        if (v[7:4] >= `RCS_NIB_NINE) begin
          r[7:4] = `RCS_NIB_ZERO;
        end else begin
          r[7:4] = v[7:4] + `RCS_NIB_ONE;
        end
      end else begin
        r = {v[7:4], v[3:0] + `RCS_NIB_ONE};
      end
    end
    return r;
  endfunction

  always_comb begin
    cen_d = cen_q;
    if (!reset) begin
      if (wr_en && count_unlock) begin
        cen_d = wdata;
      end else if (year_carry && !count_unlock) begin
        cen_d = step(cen_q, bcd_mode);
      end
    end
  end

  // No reset term: the count survives a reset
  always_ff @(posedge clk) begin
    if (ce) begin
      cen_q <= cen_d;
    end
  end

  assign century = cen_q;

  locked_write_ignored_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_en && !count_unlock && !year_carry |=> $stable(cen_q))
    else $error("century changed on a locked write");

  unlocked_write_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_en && count_unlock |=> cen_q == $past(wdata))
    else $error("century did not take an unlocked write");

  bcd_wrap_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && year_carry && !count_unlock && bcd_mode && !wr_en
      && cen_q == 8'h99 |=> cen_q == `RCS_BYTE_ZERO)
    else $error("decimal century did not wrap");

  bin_step_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && year_carry && !count_unlock && !bcd_mode
      |=> cen_q == 8'($past(cen_q) + `RCS_BYTE_ONE))
    else $error("binary century did not step by one");

  stopped_unlocked_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && count_unlock && !wr_en |=> $stable(cen_q))
    else $error("century counted while unlocked");

endmodule

// ==== logic/rcs_map.svh ====
// Register offsets, field positions and constants of the century and alarm block
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

`define RCS_ADDR_W        16
`define RCS_OFF_CENTURY   16'h00E7
`define RCS_OFF_ALARM_SECOND_LOWER_DIGIT      16'h00E8
`define RCS_OFF_ALARM_MINUTE_LOWER_DIGIT      16'h00E9
`define RCS_OFF_ALARM_HOUR_LOWER_DIGIT      16'h00EA
`define RCS_OFF_AEN       16'h00EC
`define RCS_OFF_CTRL      16'h00ED

`define RCS_CTRL_FLAG     7
`define RCS_CTRL_BCD      5
`define RCS_CTRL_UNLOCK   0

`define RCS_AEN_SEC       0
`define RCS_AEN_MIN       1
`define RCS_AEN_HRS       2
`define RCS_AEN_DOW       3
`define RCS_AEN_W         4

`define RCS_BYTE_ZERO     8'h00
`define RCS_BYTE_ONE      8'h01
`define RCS_NIB_ZERO      4'h0
`define RCS_NIB_ONE       4'h1
`define RCS_NIB_NINE      4'h9
`define RCS_AEN_ZERO      4'h0

`endif

// ==== logic/rcs_pkg.sv ====
// Shared types of the century and alarm block
package rcs_pkg;
  typedef logic [7:0]  rcs_byte_t;
  typedef logic [15:0] rcs_addr_t;
  typedef logic [3:0]  rcs_nib_t;
endpackage

// ==== logic/rcs_top.sv ====
// Century count, alarm set-points, alarm enables and control of the clock
// What this block does
// - Century register accepts writes only while the count write permit is set.
// - Decimal century: upper digit bits 7-4, lower 3-0, each 0-9.
// - Binary century: one eight-bit unsigned value from zero.
// - Reset leaves century and second, minute, hour set-points untouched.
// - Second, minute, hour set-points are readable and writable at all times except during reset (writes ignored, reads give zero).
// - Decimal alarm second: upper digit 0-5 in bits 7-4, lower 3-0.
// - Binary alarm second: eight-bit value 0 through 59.
// - Decimal alarm minute: upper digit 0-5, lower digit 0-9.
// - Binary alarm minute: eight-bit value 0 through 59.
// - Decimal alarm hour: upper digit 0-2, lower digit 0-9.
// - Binary alarm hour: eight-bit value 0 through 23.
// - Decimal select set means packed decimal everywhere, else binary.
// - Permit clear locks counts and counts; permit set unlocks, stops.
// - Separate enables for second, minute, hour, weekday comparisons.
// - Alarm flag re-evaluated on count advance while locked and on relock.
`timescale 1ns/1ps
`include "rcs_map.svh"
module rcs_top (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               ce,
  input  wire rcs_pkg::rcs_addr_t addr,
  input  wire rcs_pkg::rcs_byte_t wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output rcs_pkg::rcs_byte_t      rdata,
  input  wire rcs_pkg::rcs_byte_t count_sec,
  input  wire rcs_pkg::rcs_byte_t count_min,
  input  wire rcs_pkg::rcs_byte_t count_hour,
  input  wire rcs_pkg::rcs_byte_t count_dow,
  input  wire rcs_pkg::rcs_byte_t alarm_dow,
  input  wire logic               count_advance,
  input  wire logic               year_carry,
  output rcs_pkg::rcs_byte_t      century,
  output logic                    bcd_mode,
  output logic                    count_unlock,
  output logic                    alarm_flag
);

  // Bus decode
  logic wr_cen;
  logic wr_alarm_second_lower_digit;
  logic wr_alarm_minute_lower_digit;
  logic wr_alarm_hour_lower_digit;
  logic wr_aen;
  logic wr_ctrl;
  logic rd_ctrl;

  always_comb begin
    wr_cen  = wr && (addr == `RCS_OFF_CENTURY);
    wr_alarm_second_lower_digit = wr && (addr == `RCS_OFF_ALARM_SECOND_LOWER_DIGIT);
    wr_alarm_minute_lower_digit = wr && (addr == `RCS_OFF_ALARM_MINUTE_LOWER_DIGIT);
    wr_alarm_hour_lower_digit = wr && (addr == `RCS_OFF_ALARM_HOUR_LOWER_DIGIT);
    wr_aen  = wr && (addr == `RCS_OFF_AEN);
    wr_ctrl = wr && (addr == `RCS_OFF_CTRL);
    rd_ctrl = rd && (addr == `RCS_OFF_CTRL);
  end

  // Alarm set-points: no reset, no lock
  rcs_pkg::rcs_byte_t alarm_second_lower_digit_q;
  rcs_pkg::rcs_byte_t alarm_second_lower_digit_d;
  rcs_pkg::rcs_byte_t alarm_minute_lower_digit_q;
  rcs_pkg::rcs_byte_t alarm_minute_lower_digit_d;
  rcs_pkg::rcs_byte_t alarm_hour_lower_digit_q;
  rcs_pkg::rcs_byte_t alarm_hour_lower_digit_d;

  always_comb begin
    alarm_second_lower_digit_d = alarm_second_lower_digit_q;
    alarm_minute_lower_digit_d = alarm_minute_lower_digit_q;
    alarm_hour_lower_digit_d = alarm_hour_lower_digit_q;
    if (!reset) begin
      if (wr_alarm_second_lower_digit) begin
        alarm_second_lower_digit_d = wdata;
      end
      if (wr_alarm_minute_lower_digit) begin
        alarm_minute_lower_digit_d = wdata;
      end
      if (wr_alarm_hour_lower_digit) begin
        alarm_hour_lower_digit_d = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      alarm_second_lower_digit_q <= alarm_second_lower_digit_d;
      alarm_minute_lower_digit_q <= alarm_minute_lower_digit_d;
      alarm_hour_lower_digit_q <= alarm_hour_lower_digit_d;
    end
  end

  // Control, enables and alarm flag
  logic [`RCS_AEN_W-1:0] aen_q;
  logic [`RCS_AEN_W-1:0] aen_d;
  logic                  bcd_q;
  logic                  bcd_d;
  logic                  unlock_q;
  logic                  unlock_d;
  logic                  flag_q;
  logic                  flag_d;
  logic                  relock;
  logic                  evaluate;
  logic                  alarm_match;

  always_comb begin
    relock   = wr_ctrl && unlock_q && !wdata[`RCS_CTRL_UNLOCK];
    evaluate = (count_advance && !unlock_q) || relock;
    aen_d    = aen_q;
    bcd_d    = bcd_q;
    unlock_d = unlock_q;
    flag_d   = flag_q;
    if (wr_aen) begin
      aen_d = wdata[`RCS_AEN_W-1:0];
    end
    if (wr_ctrl) begin
      bcd_d    = wdata[`RCS_CTRL_BCD];
      unlock_d = wdata[`RCS_CTRL_UNLOCK];
    end
    // Reading control clears the flag; a match in the same cycle wins
    if (rd_ctrl) begin
      flag_d = 1'b0;
    end
    if (evaluate && alarm_match) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (reset) begin
        aen_q    <= `RCS_AEN_ZERO;
        bcd_q    <= 1'b0;
        unlock_q <= 1'b0;
        flag_q   <= 1'b0;
      end else begin
        aen_q    <= aen_d;
        bcd_q    <= bcd_d;
        unlock_q <= unlock_d;
        flag_q   <= flag_d;
      end
    end
  end

  rcs_alarm_match u_match (
    .enables    (aen_q),
    .set_sec    (alarm_second_lower_digit_q),
    .set_min    (alarm_minute_lower_digit_q),
    .set_hrs    (alarm_hour_lower_digit_q),
    .set_dow    (alarm_dow),
    .count_sec  (count_sec),
    .count_min  (count_min),
    .count_hour (count_hour),
    .count_dow  (count_dow),
    .match      (alarm_match)
  );

  rcs_century_counter u_century (
    .clk          (clk),
    .reset        (reset),
    .ce           (ce),
    .bcd_mode     (bcd_q),
    .count_unlock (unlock_q),
    .wr_en        (wr_cen),
    .wdata        (wdata),
    .year_carry   (year_carry),
    .century      (century)
  );

  // Read data, valid the cycle after the strobe; unmapped reads give zero
  rcs_pkg::rcs_byte_t rdata_q;
  rcs_pkg::rcs_byte_t rdata_d;

  always_comb begin
    rdata_d = `RCS_BYTE_ZERO;
    if (rd) begin
      unique case (addr)
        `RCS_OFF_CENTURY: rdata_d = century;
        `RCS_OFF_ALARM_SECOND_LOWER_DIGIT:    rdata_d = alarm_second_lower_digit_q;
        `RCS_OFF_ALARM_MINUTE_LOWER_DIGIT:    rdata_d = alarm_minute_lower_digit_q;
        `RCS_OFF_ALARM_HOUR_LOWER_DIGIT:    rdata_d = alarm_hour_lower_digit_q;
        `RCS_OFF_AEN: begin
          rdata_d[`RCS_AEN_W-1:0] = aen_q;
        end
        `RCS_OFF_CTRL: begin
          rdata_d[`RCS_CTRL_FLAG]   = flag_q;
          rdata_d[`RCS_CTRL_BCD]    = bcd_q;
          rdata_d[`RCS_CTRL_UNLOCK] = unlock_q;
        end
        default: rdata_d = `RCS_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (reset) begin
        rdata_q <= `RCS_BYTE_ZERO;
      end else begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign rdata        = rdata_q;
  assign bcd_mode     = bcd_q;
  assign count_unlock = unlock_q;
  assign alarm_flag   = flag_q;

  setpoint_write_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_alarm_second_lower_digit |=> alarm_second_lower_digit_q == $past(wdata))
    else $error("alarm second did not take the write");

  setpoint_readback_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && rd && addr == `RCS_OFF_ALARM_HOUR_LOWER_DIGIT |=> rdata == $past(alarm_hour_lower_digit_q))
    else $error("alarm hour read back wrong");

  reset_keeps_setpoints_a: assert property (
    @(posedge clk)
    reset && ce |=> $stable(alarm_second_lower_digit_q) && $stable(alarm_minute_lower_digit_q) && $stable(alarm_hour_lower_digit_q))
    else $error("set-point changed during reset");

  flag_raise_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && evaluate && alarm_match |=> flag_q)
    else $error("alarm flag not raised on match");

  flag_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && !flag_q && !evaluate |=> !flag_q)
    else $error("alarm flag rose without evaluation");

  flag_read_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && rd_ctrl && !(evaluate && alarm_match) |=> !flag_q)
    else $error("alarm flag not cleared by control read");

  no_enable_no_match_a: assert property (
    @(posedge clk) disable iff (reset)
    aen_q == `RCS_AEN_ZERO |-> !alarm_match)
    else $error("match with every comparison disabled");

  unlocked_no_advance_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && unlock_q && !wr_ctrl && !flag_q |=> !flag_q)
    else $error("alarm evaluated while unlocked");

  bcd_select_a: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_ctrl |=> bcd_mode == $past(wdata[`RCS_CTRL_BCD]))
    else $error("decimal select not taken");

endmodule

// ==== verification/tb_rcs_top.sv ====
// Self-checking bench of the century and alarm set-point register block
`timescale 1ns/1ps
`include "rcs_map.svh"
module tb_rcs_top;
  logic               clk;
  logic               reset;
  logic               ce;
  rcs_pkg::rcs_addr_t addr;
  rcs_pkg::rcs_byte_t wdata;
  logic               wr;
  logic               rd;
  rcs_pkg::rcs_byte_t rdata;
  rcs_pkg::rcs_byte_t cnt [4];
  rcs_pkg::rcs_byte_t sv [4];
  logic               count_advance;
  logic               year_carry;
  rcs_pkg::rcs_byte_t century;
  logic               bcd_mode;
  logic               count_unlock;
  logic               alarm_flag;
  int                 failures;
  int                 cmp_count;
  int unsigned        seed_val;
  logic               bcd;
  rcs_pkg::rcs_byte_t starts [6] = '{8'h09, 8'h99, 8'h58, 8'hFF, 8'h0F, 8'h7A};

  rcs_top u_rcs_top (
    .clk           (clk),
    .reset         (reset),
    .ce            (ce),
    .addr          (addr),
    .wdata         (wdata),
    .wr            (wr),
    .rd            (rd),
    .rdata         (rdata),
    .count_sec     (cnt[0]),
    .count_min     (cnt[1]),
    .count_hour    (cnt[2]),
    .count_dow     (cnt[3]),
    .alarm_dow     (sv[3]),
    .count_advance (count_advance),
    .year_carry    (year_carry),
    .century       (century),
    .bcd_mode      (bcd_mode),
    .count_unlock  (count_unlock),
    .alarm_flag    (alarm_flag)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic rcs_pkg::rcs_byte_t to_bcd(input int n);
    return 8'(((n / 10) << 4) | (n % 10));
  endfunction

  function automatic rcs_pkg::rcs_byte_t inc_cen(input rcs_pkg::rcs_byte_t v,
                                                 input logic b);
    if (!b || v[3:0] != 4'h9) return v + 8'h01;
    if (v[7:4] != 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return 8'h00;
  endfunction

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_byte(input rcs_pkg::rcs_byte_t got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Bus tasks start 1 ns after an edge and return 1 ns after an edge
  task automatic wr_reg(input rcs_pkg::rcs_addr_t a, rcs_pkg::rcs_byte_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input rcs_pkg::rcs_addr_t a, rcs_pkg::rcs_byte_t e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_byte(rdata, e);
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic carry);
    if (carry) year_carry <= 1'b1;
    else count_advance <= 1'b1;
    @(posedge clk);
    year_carry <= 1'b0;
    count_advance <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    #(25ns * 20000);
    failures++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    count_advance = 1'b0;
    year_carry = 1'b0;
    failures = 0;
    cmp_count = 0;
    for (int k = 0; k < 4; k++) cnt[k] = 8'h00;
    sv[3] = 8'h05;
    seed_val = $urandom(39);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    // Set-points: extremes first, then random, alternating coding forms
    for (int i = 0; i < 20; i++) begin
      sv[0] = 8'((i < 2) ? 59 : $urandom_range(59));
      sv[1] = 8'((i < 2) ? 59 : $urandom_range(59));
      sv[2] = 8'((i < 2) ? 23 : $urandom_range(23));
      if (i % 2 == 1)
        for (int k = 0; k < 3; k++) sv[k] = to_bcd(sv[k]);
      for (int k = 0; k < 3; k++) wr_reg(`RCS_OFF_ALARM_SECOND_LOWER_DIGIT + 16'(k), sv[k]);
      for (int k = 0; k < 3; k++) begin
        rd_chk(`RCS_OFF_ALARM_SECOND_LOWER_DIGIT + 16'(k), sv[k]);
      end
    end
    rd_chk(16'h00EB, 8'h00);
    // Century writes only while unlocked
    wr_reg(`RCS_OFF_CTRL, 8'h21);
    chk_bit(count_unlock, 1'b1);
    chk_bit(bcd_mode, 1'b1);
    wr_reg(`RCS_OFF_CENTURY, 8'h99);
    rd_chk(`RCS_OFF_CENTURY, 8'h99);
    rd_chk(`RCS_OFF_ALARM_SECOND_LOWER_DIGIT, sv[0]);
    wr_reg(`RCS_OFF_CTRL, 8'h20);
    wr_reg(`RCS_OFF_CENTURY, 8'h42);
    rd_chk(`RCS_OFF_CENTURY, 8'h99);
    // Carry in both codings, ignored while unlocked
    for (int j = 0; j < 6; j++) begin
      bcd = (j < 3);
      wr_reg(`RCS_OFF_CTRL, {2'b00, bcd, 5'b00001});
      wr_reg(`RCS_OFF_CENTURY, starts[j]);
      pulse(1'b1);
      chk_byte(century, starts[j]);
      wr_reg(`RCS_OFF_CTRL, {2'b00, bcd, 5'b00000});
      pulse(1'b1);
      chk_byte(century, inc_cen(starts[j], bcd));
    end
    // Reset in mid-run keeps century and set-points
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(count_unlock, 1'b0);
    rd_chk(`RCS_OFF_CENTURY, inc_cen(starts[5], 1'b0));
    for (int k = 0; k < 3; k++) begin
      rd_chk(`RCS_OFF_ALARM_SECOND_LOWER_DIGIT + 16'(k), sv[k]);
    end
    // Each enable alone: only its field matches
    for (int i = 0; i < 4; i++) begin
      wr_reg(`RCS_OFF_AEN, 8'(1 << i));
      for (int k = 0; k < 4; k++) cnt[k] <= sv[k] ^ 8'(k != i);
      pulse(1'b0);
      chk_bit(alarm_flag, 1'b1);
      rd_chk(`RCS_OFF_CTRL, 8'h80);
      chk_bit(alarm_flag, 1'b0);
      wr_reg(`RCS_OFF_AEN, 8'h0F);
      pulse(1'b0);
      chk_bit(alarm_flag, 1'b0);
    end
    // Full match while unlocked, then relock evaluates
    for (int k = 0; k < 4; k++) cnt[k] <= sv[k];
    wr_reg(`RCS_OFF_CTRL, 8'h01);
    pulse(1'b0);
    chk_bit(alarm_flag, 1'b0);
    wr_reg(`RCS_OFF_CTRL, 8'h00);
    chk_bit(alarm_flag, 1'b1);
    rd_chk(`RCS_OFF_CTRL, 8'h80);
    report_and_stop();
  end
endmodule
